// *** logic/sre_status_queue.sv ***
// Function
// - Condition query returns live condition bits, no side effects.
// - Event query returns latched bits and clears them together.
// - Questionable summary is OR of events gated by enable mask.
// - Enable query returns stored questionable mask.
// - Preset zeroes questionable enable only, nothing else.
// - Status byte bits 7,6,5,4,3: operation, request, event, message, questionable.
// - Standard event mask readable; summary is OR of masked events.
// - Each detected error pushes code and message id to queue, except an external error in the same cycle as a clamp error.
// - Each error query pops exactly the oldest entry.
// - Query on empty queue returns code zero, no-error message.
// - Clear-status empties the error queue at once.
// - Twenty entries; overflow replaces newest with too-many-errors.
// - After overflow, further errors rejected until a pop.
// - Out-of-range offset clamped to limit, settings-conflict error queued.
// - Termination change outside an offset-write cycle doubles or halves offset without error.
// - Version query returns year and one-digit revision.
`timescale 1ns/100ps
`default_nettype none
module sre_status_queue
  import sre_pkg::*;
#(
  parameter int QW    = 16,
  parameter int DEPTH = ERRQ_DEPTH
) (
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic [QW-1:0] ques_cond,
  input  wire logic          ques_cond_rd,
  input  wire logic          ques_evt_rd,
  input  wire logic          ques_en_wr,
  input  wire logic [QW-1:0] ques_en_wdata,
  input  wire logic          ques_en_rd,
  input  wire logic          status_preset,
  input  wire logic [7:0]    std_event,
  input  wire logic          ese_wr,
  input  wire logic [7:0]    ese_wdata,
  input  wire logic          ese_rd,
  input  wire logic          operation_summary_bit,
  input  wire logic          service_request_bit,
  input  wire logic          message_available_bit,
  input  wire logic          err_push,
  input  wire logic [15:0]   err_code,
  input  wire logic [7:0]    err_msg,
  input  wire logic          err_rd,
  input  wire logic          clear_status,
  input  wire logic          offset_wr,
  input  wire logic [15:0]   offset_req,
  input  wire logic [15:0]   offset_limit,
  input  wire logic          output_termination_select,
  input  wire logic          version_rd,
  output var  logic [15:0]   rd_data,
  output var  logic [7:0]    rd_msg,
  output var  logic          rd_valid,
  output var  logic [7:0]    status_summary_byte,
  output var  logic [15:0]   offset_value
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

  logic [QW-1:0] ques_evt;
  logic [QW-1:0] ques_en;
  logic [QW-1:0] next_ques_en;
  logic [7:0]    ese;
  logic [7:0]    next_ese;

  // Event bits, one latch per condition
  for (genvar i = 0; i < QW; i++) begin : g_evt
    sre_ques_bit u_bit (
      .clk_sys (clk_sys),
      .srst    (srst),
      .cond    (ques_cond[i]),
      .clr     (ques_evt_rd),
      .evt     (ques_evt[i])
    );
  end

  always_comb begin
    next_ques_en = ques_en;
    next_ese     = ese;
    if (status_preset) begin
      next_ques_en = '0;
    end else if (ques_en_wr) begin
      next_ques_en = ques_en_wdata;
    end
    if (ese_wr) begin
      next_ese = ese_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ques_en <= QUES_RESET;
      ese     <= ESE_RESET;
    end else begin
      ques_en <= next_ques_en;
      ese     <= next_ese;
    end
  end

  // Offset clamp and termination scaling
  logic               term_d;
  logic        [15:0] next_offset;
  logic               clamp_err;
  logic signed [15:0] req_s;
  logic        [15:0] req_mag;

  always_comb begin
    req_s       = $signed(offset_req);
    req_mag     = req_s[15] ? 16'(-req_s) : offset_req;
    next_offset = offset_value;
    clamp_err   = 1'b0;
    if (offset_wr) begin
      if (req_mag > offset_limit) begin
        next_offset = req_s[15] ? 16'(-$signed(offset_limit)) : offset_limit;
        clamp_err   = 1'b1;
      end else begin
        next_offset = offset_req;
      end
    end else if (output_termination_select != term_d) begin
      // High impedance doubles, back to fifty ohms halves
      next_offset = output_termination_select ? {offset_value[14:0], 1'b0}
                                              : {offset_value[15], offset_value[15:1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      offset_value <= OFFSET_RESET;
      term_d       <= 1'b0;
    end else begin
      offset_value <= next_offset;
      term_d       <= output_termination_select;
    end
  end

  // Error queue
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  logic          ovf;
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [AW:0]   next_count;
  logic          next_ovf;
  logic          mem_we;
  logic [AW-1:0] mem_waddr;
  logic [23:0]   mem_wdata;
  logic [23:0]   mem_rdata;
  logic          push_any;
  logic [15:0]   push_code;
  logic [7:0]    push_msg;
  logic          pop;

  // Internal clamp error takes priority over an external one in the same cycle
  assign push_any  = err_push | clamp_err;
  assign push_code = clamp_err ? ERR_SETTINGS : err_code;
  assign push_msg  = clamp_err ? MSG_SETTINGS : err_msg;
  assign pop       = err_rd && (count != '0);

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == LAST) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    next_wptr  = wptr;
    next_rptr  = rptr;
    next_count = count;
    next_ovf   = ovf;
    mem_we     = 1'b0;
    mem_waddr  = wptr;
    mem_wdata  = {push_code, push_msg};
    if (clear_status) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
      next_ovf   = 1'b0;
    end else begin
      if (pop) begin
        next_rptr = inc(rptr);
        next_ovf  = 1'b0;
      end
      if (push_any && !ovf) begin
        if (count == FULL && !pop) begin
          // Newest slot sits just behind the write pointer
          mem_we    = 1'b1;
          mem_waddr = (wptr == '0) ? LAST : wptr - AW'(1);
          mem_wdata = {ERR_TOO_MANY, MSG_TOO_MANY};
          next_ovf  = 1'b1;
        end else begin
          mem_we    = 1'b1;
          next_wptr = inc(wptr);
        end
      end
      next_count = count + (AW+1)'(mem_we && mem_waddr == wptr) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
      ovf   <= 1'b0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
      ovf   <= next_ovf;
    end
  end

  sre_err_mem #(.W(24), .D(DEPTH), .AW(AW)) u_mem (
    .clk_sys (clk_sys),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (rptr),
    .rdata   (mem_rdata)
  );

  // Read-back path; memory data lags one cycle so queue answers are staged
  typedef enum logic [2:0] {SRE_R_NONE, SRE_R_COND, SRE_R_EVT, SRE_R_EN, SRE_R_ESE,
                            SRE_R_ERR, SRE_R_EMPTY, SRE_R_VER} sre_rsel_t;
  sre_rsel_t   rsel;
  sre_rsel_t   next_rsel;
  logic [15:0] rcap;
  logic [15:0] next_rcap;
  logic [15:0] next_rd_data;
  logic [7:0]  next_rd_msg;
  logic [7:0]  next_stb;

  always_comb begin
    next_rsel = SRE_R_NONE;
    next_rcap = '0;
    if (ques_cond_rd) begin
      next_rsel = SRE_R_COND;
      next_rcap = ques_cond;
    end else if (ques_evt_rd) begin
      next_rsel = SRE_R_EVT;
      next_rcap = ques_evt;
    end else if (ques_en_rd) begin
      next_rsel = SRE_R_EN;
      next_rcap = ques_en;
    end else if (ese_rd) begin
      next_rsel = SRE_R_ESE;
      next_rcap = {8'h00, ese};
    end else if (err_rd) begin
      next_rsel = (count != '0) ? SRE_R_ERR : SRE_R_EMPTY;
    end else if (version_rd) begin
      next_rsel = SRE_R_VER;
      next_rcap = {VERSION_YEAR[11:0], VERSION_REV};
    end
  end

  always_comb begin
    next_rd_data = rcap;
    next_rd_msg  = MSG_NONE;
    unique case (rsel)
      SRE_R_ERR: begin
        next_rd_data = mem_rdata[23:8];
        next_rd_msg  = mem_rdata[7:0];
      end
      SRE_R_EMPTY: begin
        next_rd_data = ERR_NONE;
        next_rd_msg  = MSG_NONE;
      end
      SRE_R_VER: begin
        next_rd_data = VERSION_YEAR;
        next_rd_msg  = {4'h0, VERSION_REV};
      end
      SRE_R_NONE, SRE_R_COND, SRE_R_EVT, SRE_R_EN, SRE_R_ESE: begin
        next_rd_data = rcap;
      end
    endcase
    next_stb = '0;
    next_stb[STB_OPERATION_POS] = operation_summary_bit;
    next_stb[STB_SERVICE_POS]   = service_request_bit;
    next_stb[STB_STD_EVENT_POS] = |(std_event & ese);
    next_stb[STB_MESSAGE_POS]   = message_available_bit;
    next_stb[STB_QUES_POS]      = |(ques_evt & ques_en);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsel                <= SRE_R_NONE;
      rcap                <= '0;
      rd_data             <= '0;
      rd_msg              <= '0;
      rd_valid            <= 1'b0;
      status_summary_byte <= '0;
    end else begin
      rsel                <= next_rsel;
      rcap                <= next_rcap;
      rd_data             <= next_rd_data;
      rd_msg              <= next_rd_msg;
      rd_valid            <= (rsel != SRE_R_NONE);
      status_summary_byte <= next_stb;
    end
  end

  ques_summary_a: assert property (@(posedge clk_sys) disable iff (srst)
    status_summary_byte[STB_QUES_POS] == $past(|(ques_evt & ques_en)))
    else $error("questionable summary mismatch");
  preset_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    status_preset |=> ques_en == '0)
    else $error("preset did not zero enable");
  clear_empty_a: assert property (@(posedge clk_sys) disable iff (srst)
    clear_status |=> count == '0)
    else $error("clear left entries");
  depth_bound_a: assert property (@(posedge clk_sys) disable iff (srst)
    count <= FULL)
    else $error("queue over depth");
  ovf_reject_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ovf && !err_rd && !clear_status) |=> count == $past(count))
    else $error("error accepted after overflow");
  empty_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (err_rd && count == '0 && !ques_cond_rd && !ques_evt_rd && !ques_en_rd && !ese_rd)
      |=> ##1 rd_valid && rd_data == ERR_NONE)
    else $error("empty queue read not zero");
  evt_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ques_evt_rd && ques_cond == $past(ques_cond)) |=> ques_evt == '0)
    else $error("event not cleared by read");
  clamp_push_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clamp_err && !ovf && count < FULL && !clear_status) |=> count != '0)
    else $error("clamp error not queued");
  ese_summary_a: assert property (@(posedge clk_sys) disable iff (srst)
    status_summary_byte[STB_STD_EVENT_POS] == $past(|(std_event & ese)))
    else $error("standard event summary mismatch");
endmodule
`default_nettype wire

// *** pkg/sre_pkg.sv ***
package sre_pkg;

  // Status byte bit positions
  localparam int STB_OPERATION_POS = 7;
  localparam int STB_SERVICE_POS   = 6;
  localparam int STB_STD_EVENT_POS = 5;
  localparam int STB_MESSAGE_POS   = 4;
  localparam int STB_QUES_POS      = 3;

  // Error codes, two's complement 16 bit
  localparam logic [15:0] ERR_NONE          = 16'h0000;
  localparam logic [15:0] ERR_SETTINGS      = 16'hFF23; // -221
  localparam logic [15:0] ERR_TOO_MANY      = 16'hFEA2; // -350
  localparam logic [7:0]  MSG_NONE          = 8'h00;
  localparam logic [7:0]  MSG_SETTINGS      = 8'h01;
  localparam logic [7:0]  MSG_TOO_MANY      = 8'h02;

  // Reset values
  localparam logic [15:0] QUES_RESET        = 16'h0000;
  localparam logic [7:0]  ESE_RESET         = 8'h00;
  localparam logic [15:0] OFFSET_RESET      = 16'h0000;

  // Command-language version, arbitrary value
  localparam logic [15:0] VERSION_YEAR      = 16'h07CF;
  localparam logic [3:0]  VERSION_REV       = 4'h0;

  localparam int ERRQ_DEPTH = 20;

endpackage

// *** logic/sre_err_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module sre_err_mem
  import sre_pkg::*;
#(
  parameter int W = 24,
  parameter int D = 20,
  parameter int AW = 5
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [W-1:0]  rdata
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// *** logic/sre_ques_bit.sv ***
`timescale 1ns/100ps
`default_nettype none
module sre_ques_bit
  import sre_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic cond,
  input  wire logic clr,
  output var  logic evt
);
  logic cond_d;
  logic next_evt;
  logic next_cond_d;

  // Set beats clear so a rising edge in the read cycle is kept
  always_comb begin
    next_cond_d = cond;
    next_evt    = evt;
    if (clr) begin
      next_evt = 1'b0;
    end
    if (cond && !cond_d) begin
      next_evt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evt    <= 1'b0;
      cond_d <= 1'b0;
    end else begin
      evt    <= next_evt;
      cond_d <= next_cond_d;
    end
  end

  // A rise must latch even when a read clears in the same cycle
  evt_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    (cond && !cond_d) |=> evt)
    else $error("event bit missed a rising condition");
endmodule
`default_nettype wire

// *** bench/sre_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sre_host_model (
  input  wire logic       clk_sys,
  input  wire logic       rd_valid,
  output var  logic [5:0] qry,
  output var  logic       clear_status
);
  initial begin
    qry          = 6'h00;
    clear_status = 1'b0;
  end

  // One query in flight; nothing relies on its effect before the answer shows
  task automatic query(input int k, output logic ok);
    int n;
    @(posedge clk_sys);
    #1 qry[k] = 1'b1;
    @(posedge clk_sys);
    #1 qry[k] = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1 n++;
    end
    ok = rd_valid;
  endtask

  // Stale entries from earlier traffic would spoil later reads, so clear first
  task automatic clr();
    @(posedge clk_sys);
    #1 clear_status = 1'b1;
    @(posedge clk_sys);
    #1 clear_status = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/status_report_and_error_queue_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module status_report_and_error_queue_bench
  import sre_pkg::*;
;
  logic        clk_sys;
  logic        srst;
  logic [15:0] ques_cond;
  logic [15:0] ques_en_wdata;
  logic [15:0] err_code;
  logic [15:0] offset_req;
  logic [15:0] offset_limit;
  logic [7:0]  std_event;
  logic [7:0]  ese_wdata;
  logic [7:0]  err_msg;
  logic        ques_en_wr;
  logic        status_preset;
  logic        ese_wr;
  logic        err_push;
  logic        offset_wr;
  logic        operation_summary_bit;
  logic        service_request_bit;
  logic        message_available_bit;
  logic        output_termination_select;
  logic [5:0]  qry;
  logic        clear_status;
  logic [15:0] rd_data;
  logic [15:0] offset_value;
  logic [7:0]  rd_msg;
  logic [7:0]  status_summary_byte;
  logic        rd_valid;
  int          miscompares;
  int          checks;

  sre_status_queue uut (
    .clk_sys(clk_sys), .srst(srst), .ques_cond(ques_cond),
    .ques_cond_rd(qry[0]), .ques_evt_rd(qry[1]), .ques_en_rd(qry[2]),
    .ques_en_wr(ques_en_wr), .ques_en_wdata(ques_en_wdata),
    .status_preset(status_preset), .std_event(std_event), .ese_wr(ese_wr),
    .ese_wdata(ese_wdata), .ese_rd(qry[3]),
    .operation_summary_bit(operation_summary_bit),
    .service_request_bit(service_request_bit),
    .message_available_bit(message_available_bit),
    .err_push(err_push), .err_code(err_code), .err_msg(err_msg), .err_rd(qry[4]),
    .clear_status(clear_status), .offset_wr(offset_wr), .offset_req(offset_req),
    .offset_limit(offset_limit), .output_termination_select(output_termination_select),
    .version_rd(qry[5]), .rd_data(rd_data), .rd_msg(rd_msg), .rd_valid(rd_valid),
    .status_summary_byte(status_summary_byte), .offset_value(offset_value)
  );

  sre_host_model host (
    .clk_sys(clk_sys), .rd_valid(rd_valid), .qry(qry), .clear_status(clear_status)
  );

  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Message id is only meaningful for error and version answers
  task automatic q(input int k, input logic [23:0] e);
    logic ok;
    host.query(k, ok);
    chk({7'h00, ok, (k >= 4) ? rd_msg : 8'h00, rd_data}, {8'h01, e});
  endtask

  // k: 0 enable write, 1 event mask write, 2 preset, 3 offset request
  task automatic wr(input int k, input logic [15:0] v);
    tick(1);
    {offset_wr, status_preset, ese_wr, ques_en_wr} = 4'(1 << k);
    ques_en_wdata = v;
    ese_wdata     = v[7:0];
    offset_req    = v;
    tick(1);
    {offset_wr, status_preset, ese_wr, ques_en_wr} = 4'h0;
  endtask

  task automatic push(input logic [15:0] c, input logic [7:0] m);
    tick(1);
    err_push = 1'b1;
    err_code = c;
    err_msg  = m;
    tick(1);
    err_push = 1'b0;
  endtask

  // Status byte lags a register write by two edges
  task automatic sb(input logic [7:0] e);
    tick(3);
    chk({24'h00_0000, status_summary_byte}, {24'h00_0000, e});
  endtask

  task automatic ov(input logic [15:0] e);
    tick(2);
    chk({16'h0000, offset_value}, {16'h0000, e});
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // The whole sequence needs well under a thousand cycles; 5000 leaves ample margin
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial begin
    srst = 1'b1;
    {ques_cond, ques_en_wdata, err_code, offset_req} = 64'h0;
    offset_limit = 16'h0100;
    {std_event, ese_wdata, err_msg} = 24'h00_0000;
    {ques_en_wr, status_preset, ese_wr, err_push, offset_wr} = 5'h00;
    {operation_summary_bit, service_request_bit, message_available_bit} = 3'h0;
    output_termination_select = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (10) @(posedge clk_sys);
    #1 srst = 1'b0;
    host.clr();
    q(1, 24'h00_0000);
    q(2, 24'h00_0000);
    q(4, 24'h00_0000);
    ques_cond = 16'h00a5;
    tick(2);
    q(0, 24'h00_00a5);
    q(1, 24'h00_00a5);
    q(1, 24'h00_0000);
    q(0, 24'h00_00a5);
    ques_cond = 16'h0000;
    tick(1);
    ques_cond = 16'h0006;
    wr(0, 16'h0004);
    sb(8'h08);
    wr(0, 16'h0001);
    sb(8'h00);
    q(2, 24'h00_0001);
    wr(2, 16'h0000);
    q(2, 24'h00_0000);
    q(1, 24'h00_0006);
    std_event = 8'h21;
    wr(1, 16'h0001);
    {operation_summary_bit, service_request_bit, message_available_bit} = 3'h5;
    sb(8'hb0);
    wr(1, 16'h0002);
    {operation_summary_bit, service_request_bit, message_available_bit} = 3'h2;
    sb(8'h40);
    q(3, 24'h00_0002);
    for (int i = 1; i <= 21; i++) push(16'(i), 8'(i));
    push(16'h0077, 8'h07);
    q(4, 24'h01_0001);
    push(16'h0055, 8'h05);
    for (int i = 2; i <= 19; i++) q(4, {8'(i), 16'(i)});
    q(4, {MSG_TOO_MANY, ERR_TOO_MANY});
    q(4, 24'h05_0055);
    q(4, 24'h00_0000);
    push(16'h0011, 8'h01);
    push(16'h0022, 8'h02);
    host.clr();
    q(4, 24'h00_0000);
    wr(3, 16'h0040);
    ov(16'h0040);
    output_termination_select = 1'b1;
    ov(16'h0080);
    output_termination_select = 1'b0;
    ov(16'h0040);
    q(4, 24'h00_0000);
    wr(3, 16'h0300);
    ov(16'h0100);
    q(4, {MSG_SETTINGS, ERR_SETTINGS});
    // Negative request clamps to the negative limit; scaling keeps the sign
    wr(3, 16'hfd00);
    ov(16'hff00);
    q(4, {MSG_SETTINGS, ERR_SETTINGS});
    output_termination_select = 1'b1;
    ov(16'hfe00);
    output_termination_select = 1'b0;
    ov(16'hff00);
    q(4, 24'h00_0000);
    q(5, {4'h0, VERSION_REV, VERSION_YEAR});
    finish_test();
  end
endmodule
`default_nettype wire
